// ### ueps_host_model.sv
// Far side stand-in: line state and protocol events toward the status block
`timescale 1ns/100ps
`default_nettype none
module ueps_host_model (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // Commands from the bench
   input  wire logic                go,
   input  wire ueps_pkg::ueps_evt_t cmd,
   input  wire logic                lineUp,
   input  wire logic                resetSig,
   // Toward the block
   output ueps_pkg::ueps_evt_t      evt,
   output logic                     busNonIdle,
   output logic                     busReset
);
   // One event per cycle, held for one cycle only
   always_ff @(posedge clk) begin
      evt        <= (go && !rst) ? cmd : '0;
      busNonIdle <= lineUp;
      busReset   <= resetSig;
   end
endmodule : ueps_host_model
`default_nettype wire

// ### ueps_pkg.sv
// Package: register map, field positions, types and timing for the endpoint status block
package ueps_pkg;
   // ==========================================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_PTR_LO      = 8'h06;
   localparam logic [7:0] IDX_PTR_HI      = 8'h07;
   localparam logic [7:0] IDX_IRQ_A       = 8'h08;
   localparam logic [7:0] IDX_IRQ_B       = 8'h09;
   localparam logic [7:0] IDX_FLAGS_A_CLR = 8'h0a;
   localparam logic [7:0] IDX_FLAGS_A_SET = 8'h0b;
   localparam logic [7:0] IDX_FLAGS_B_CLR = 8'h0c;
   localparam logic [7:0] IDX_FLAGS_B_SET = 8'h0d;
   localparam logic [7:0] IDX_FIFO_POP    = 8'h0e;
   localparam logic [7:0] IDX_TRIM_LO     = 8'h3a;
   localparam logic [7:0] IDX_TRIM_HI     = 8'h3b;
   localparam logic [1:0] IDX_EP_WIN      = 2'h1;
   // ==========================================================================
   // Field positions
   localparam int FA_SUSPEND = 6;
   localparam int FA_RESUME  = 5;
   localparam int FA_BUSRST  = 4;
   localparam int FA_CRC     = 3;
   localparam int FA_UNF     = 2;
   localparam int FA_OVF     = 1;
   localparam int FA_STALL   = 0;
   localparam int FB_TRN     = 1;
   localparam int FB_SETUP   = 0;
   localparam int IA_BUSEV   = 6;
   localparam int IA_BUSERR  = 5;
   localparam int IA_STALL   = 4;
   localparam int ST_STALL   = 7;
   localparam int ST_UNFOVF  = 6;
   localparam int ST_DONEIO  = 5;
   localparam int ST_DONEANY = 4;
   localparam int ST_BANK    = 3;
   localparam int ST_NAK1    = 2;
   localparam int ST_NAK0    = 1;
   localparam int ST_TOGGLE  = 0;
   localparam int CT_MULTI   = 5;
   localparam int CT_PING    = 4;
   localparam int CT_INHIBIT = 3;
   localparam int CT_STALL   = 2;
   localparam logic [7:0] ST_W1C_MASK  = 8'hbe;
   localparam logic [7:0] FA_MASK      = 8'h7f;
   localparam logic [7:0] FB_MASK      = 8'h03;
   localparam logic [7:0] IA_MASK      = 8'h73;
   localparam logic [7:0] RST_BYTE     = 8'h00;
   localparam logic [10:0] MIN_PAYLOAD = 11'h008;
   localparam logic [10:0] ISO_MAX     = 11'h3ff;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   // ==========================================================================
   // Timing
   localparam int CLK_HZ        = 10_000_000;
   localparam int IDLE_SUSP_MS  = 3;
   localparam int IDLE_SUSP_CYC = CLK_HZ / 1000 * IDLE_SUSP_MS;
   // ==========================================================================
   // Types
   typedef enum logic [1:0] {EP_DISABLED = 2'h0, EP_CONTROL = 2'h1, EP_BULK = 2'h2, EP_ISO = 2'h3} ueps_ep_type_t;
   typedef enum logic [1:0] {BUS_ACTIVE = 2'h1, BUS_SUSPENDED = 2'h2} ueps_bus_state_t;
   typedef struct packed {
      logic       valid;
      logic [3:0] epNum;
      logic       dirIn;
      logic       setup;
      logic       success;
      logic       stall;
      logic       unfOvf;
      logic       crcErr;
   } ueps_evt_t;
endpackage : ueps_pkg

// ### ueps_status_flags.sv
// Endpoint status table, bus event flags and pad trim behind an AXI4-Lite slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module ueps_status_flags #(
   parameter int IDLE_CYC = ueps_pkg::IDLE_SUSP_CYC
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // AXI4-Lite slave
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [11:0]       awaddr,
   input  wire logic              wvalid,
   output logic                   wready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   output logic                   bvalid,
   input  wire logic              bready,
   output logic [1:0]             bresp,
   input  wire logic              arvalid,
   output logic                   arready,
   input  wire logic [11:0]       araddr,
   output logic                   rvalid,
   input  wire logic              rready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   // Bus conditions from the line state logic
   input  wire logic              busReset,
   input  wire logic              busNonIdle,
   // Transaction events from the protocol engine
   input  wire ueps_pkg::ueps_evt_t evt,
   // Endpoint lookup for the protocol engine
   input  wire logic [4:0]        lkEp,
   input  wire logic [10:0]       rxByteCount,
   output ueps_pkg::ueps_ep_type_t lkType,
   output logic [15:0]            lkAddr,
   output logic                   lkNak,
   output logic                   lkToggle,
   output logic                   lkToggleCheck,
   output logic                   lkStall,
   output logic                   lkMulti,
   output logic [10:0]            lkMaxBytes,
   output logic                   rxDiscard,
   // Pad trim, wake and interrupt
   output logic [15:0]            padTrim,
   output logic                   wakeRequest,
   output logic                   irq
);
   // ==========================================================================
   // Register bus decode
   logic        bvalid_q, rvalid_q;
   logic [1:0]  bresp_q, rresp_q;
   logic [31:0] rdata_q;
   wire         wrGo   = awvalid && wvalid && !bvalid_q;
   wire         rdGo   = arvalid && !rvalid_q;
   wire  [7:0]  wIdx   = awaddr[9:2];
   wire  [7:0]  rIdx   = araddr[9:2];
   wire         wEn    = wrGo && wstrb[0];
   wire  [7:0]  wb     = wdata[7:0];
   wire         epWr   = wEn && awaddr[11:10] == 2'h0 && wIdx[7:6] == ueps_pkg::IDX_EP_WIN;
   wire         wrA    = wEn && wIdx == ueps_pkg::IDX_FLAGS_A_SET;
   wire         wcA    = wEn && wIdx == ueps_pkg::IDX_FLAGS_A_CLR;
   wire         wrB    = wEn && wIdx == ueps_pkg::IDX_FLAGS_B_SET;
   wire         wcB    = wEn && wIdx == ueps_pkg::IDX_FLAGS_B_CLR;
   wire  [7:0]  setSwA = wrA ? (wb & ueps_pkg::FA_MASK) : 8'h00;
   wire  [7:0]  clrSwA = wcA ? (wb & ueps_pkg::FA_MASK) : 8'h00;
   wire  [7:0]  setSwB = wrB ? (wb & ueps_pkg::FB_MASK) : 8'h00;
   wire  [7:0]  clrSwB = wcB ? (wb & ueps_pkg::FB_MASK) : 8'h00;
   wire         wMapHi = awaddr[11:10] == 2'h0;
   wire         wMap   = wMapHi && (wIdx[7:6] == ueps_pkg::IDX_EP_WIN || wrA || wcA || wrB || wcB
                         || wIdx == ueps_pkg::IDX_PTR_LO || wIdx == ueps_pkg::IDX_PTR_HI
                         || wIdx == ueps_pkg::IDX_IRQ_A || wIdx == ueps_pkg::IDX_IRQ_B
                         || wIdx == ueps_pkg::IDX_FLAGS_A_SET || wIdx == ueps_pkg::IDX_FLAGS_A_CLR
                         || wIdx == ueps_pkg::IDX_FLAGS_B_SET || wIdx == ueps_pkg::IDX_FLAGS_B_CLR
                         || wIdx == ueps_pkg::IDX_FIFO_POP
                         || wIdx == ueps_pkg::IDX_TRIM_LO || wIdx == ueps_pkg::IDX_TRIM_HI);

   assign awready = wrGo;
   assign wready  = wrGo;
   assign arready = rdGo;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign rvalid  = rvalid_q;
   assign rresp   = rresp_q;
   assign rdata   = rdata_q;

   // ==========================================================================
   // Plain control registers
   logic [15:0] ptr_q, trim_q;
   logic [7:0]  irqA_q, irqB_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         ptr_q  <= 16'h0000;
         trim_q <= 16'h0000;
         irqA_q <= ueps_pkg::RST_BYTE;
         irqB_q <= ueps_pkg::RST_BYTE;
      end else if (wEn && wMapHi) begin
         if (wIdx == ueps_pkg::IDX_PTR_LO) ptr_q[7:0] <= {wb[7:1], 1'b0};
         if (wIdx == ueps_pkg::IDX_PTR_HI) ptr_q[15:8] <= wb;
         if (wIdx == ueps_pkg::IDX_TRIM_LO) trim_q[7:0] <= wb;
         if (wIdx == ueps_pkg::IDX_TRIM_HI) trim_q[15:8] <= wb;
         if (wIdx == ueps_pkg::IDX_IRQ_A) irqA_q <= wb & ueps_pkg::IA_MASK;
         if (wIdx == ueps_pkg::IDX_IRQ_B) irqB_q <= wb & ueps_pkg::FB_MASK;
      end
   end
   assign padTrim = trim_q;

   // ==========================================================================
   // Endpoint table: 16 addresses, OUT at even entry, IN at odd entry
   logic [7:0] epStat [32];
   logic [7:0] epCtrl [32];
   wire  [4:0] evtIdx  = {evt.epNum, evt.dirIn};
   wire  [7:0] evtCtl  = epCtrl[evtIdx];
   wire        evtIso  = evtCtl[7:6] == ueps_pkg::EP_ISO;
   wire        evtEn   = evt.valid && evtCtl[7:6] != ueps_pkg::EP_DISABLED;
   wire        evtOk   = evtEn && evt.success;

   for (genvar e = 0; e < 32; e++) begin : gEp
      logic [7:0] stat_q, ctrl_q;
      wire        hit    = evtEn && evtIdx == 5'(e);
      wire        swStat = epWr && wIdx[5:0] == {5'(e), 1'b0};
      wire        swCtrl = epWr && wIdx[5:0] == {5'(e), 1'b1};
      wire        iso    = ctrl_q[7:6] == ueps_pkg::EP_ISO;
      // Consumed buffer stays refused until software clears its NAK bit
      wire        bankUsed = ctrl_q[ueps_pkg::CT_PING] && stat_q[ueps_pkg::ST_BANK];
      wire [7:0]  base   = swStat ? ((stat_q & ueps_pkg::ST_W1C_MASK & ~wb) | (wb & ~ueps_pkg::ST_W1C_MASK))
                                  : stat_q;
      wire [7:0]  setM   = {hit && ((evt.stall && !iso) || (evt.crcErr && iso && !evt.dirIn)),
                            hit && evt.unfOvf,
                            hit && evt.success && !evt.setup,
                            hit && evt.success,
                            1'b0, hit && evt.success && bankUsed,
                            hit && evt.success && !bankUsed, 1'b0};
      wire [7:0]  flipM  = {4'h0, hit && evt.success && ctrl_q[ueps_pkg::CT_PING],
                            2'h0, hit && evt.success && !iso};
      always_ff @(posedge clk) begin
         if (rst) begin
            stat_q <= ueps_pkg::RST_BYTE;
            ctrl_q <= ueps_pkg::RST_BYTE;
         end else begin
            stat_q <= (base | setM) ^ flipM;
            if (swCtrl) ctrl_q <= wb;
         end
      end
      assign epStat[e] = stat_q;
      assign epCtrl[e] = ctrl_q;
   end

   // ==========================================================================
   // Lookup for the protocol engine, registered
   wire [7:0]  lkS    = epStat[lkEp];
   wire [7:0]  lkC    = epCtrl[lkEp];
   wire        lkIso  = lkC[7:6] == ueps_pkg::EP_ISO;
   wire [2:0]  lkSz   = lkIso ? lkC[2:0] : {1'b0, lkC[1:0]};
   wire [10:0] lkMax  = lkSz == 3'h7 ? ueps_pkg::ISO_MAX : (ueps_pkg::MIN_PAYLOAD << lkSz);
   wire        lkBank = lkC[ueps_pkg::CT_PING] && lkS[ueps_pkg::ST_BANK];
   wire [15:0] lkA    = ptr_q + {8'h00, lkEp, 3'h0};
   always_ff @(posedge clk) begin
      if (rst) begin
         lkType        <= ueps_pkg::EP_DISABLED;
         lkAddr        <= 16'h0000;
         lkNak         <= 1'b0;
         lkToggle      <= 1'b0;
         lkToggleCheck <= 1'b0;
         lkStall       <= 1'b0;
         lkMulti       <= 1'b0;
         lkMaxBytes    <= ueps_pkg::MIN_PAYLOAD;
         rxDiscard     <= 1'b0;
      end else begin
         lkType        <= ueps_pkg::ueps_ep_type_t'(lkC[7:6]);
         lkAddr        <= lkA;
         lkNak         <= lkBank ? lkS[ueps_pkg::ST_NAK1] : lkS[ueps_pkg::ST_NAK0];
         lkToggle      <= lkS[ueps_pkg::ST_TOGGLE] && !lkIso;
         lkToggleCheck <= !lkIso;
         lkStall       <= lkC[ueps_pkg::CT_STALL];
         lkMulti       <= lkC[ueps_pkg::CT_MULTI];
         lkMaxBytes    <= lkMax;
         rxDiscard     <= rxByteCount >= lkMax;
      end
   end

   // ==========================================================================
   // Suspend detection
   ueps_pkg::ueps_bus_state_t busState_q;
   logic [31:0] idleCnt_q;
   wire         idleDone = busState_q == ueps_pkg::BUS_ACTIVE && idleCnt_q == 32'(IDLE_CYC - 1);
   always_ff @(posedge clk) begin
      if (rst) begin
         busState_q <= ueps_pkg::BUS_ACTIVE;
         idleCnt_q  <= 32'h0;
      end else if (busNonIdle || busReset) begin
         busState_q <= ueps_pkg::BUS_ACTIVE;
         idleCnt_q  <= 32'h0;
      end else begin
         case (busState_q)
            ueps_pkg::BUS_ACTIVE: begin
               if (idleDone) busState_q <= ueps_pkg::BUS_SUSPENDED;
               else idleCnt_q <= idleCnt_q + 32'h1;
            end
            ueps_pkg::BUS_SUSPENDED: busState_q <= ueps_pkg::BUS_SUSPENDED;
            default: busState_q <= ueps_pkg::BUS_ACTIVE;
         endcase
      end
   end

   // ==========================================================================
   // Flags A; resume presets without the clock so a stopped core can wake
   logic [7:0] flagsA_q;
   logic       resume_q;
   wire        wakeAsync = busState_q == ueps_pkg::BUS_SUSPENDED && busNonIdle;
   wire [7:0]  setHwA = {1'b0, idleDone, 1'b0,
                         busReset,
                         evtEn && evt.crcErr && evtIso,
                         evtEn && evt.unfOvf && evt.dirIn,
                         evtEn && evt.unfOvf && !evt.dirIn,
                         evtEn && evt.stall};
   always_ff @(posedge clk) begin
      if (rst) flagsA_q <= ueps_pkg::RST_BYTE;
      else flagsA_q <= (flagsA_q & ~clrSwA) | setHwA | setSwA;
   end
   always_ff @(posedge clk or posedge wakeAsync) begin
      if (wakeAsync) resume_q <= 1'b1;
      else if (rst) resume_q <= 1'b0;
      else resume_q <= (resume_q && !clrSwA[ueps_pkg::FA_RESUME]) || setSwA[ueps_pkg::FA_RESUME];
   end
   wire [7:0] flagsA = {flagsA_q[7:6], resume_q, flagsA_q[4:0]};
   assign wakeRequest = resume_q;

   // ==========================================================================
   // Completion FIFO of entry addresses, skipped for inhibited endpoints
   logic [15:0] fifoMem [16];
   logic [4:0]  wrPtr_q, rdPtr_q;
   wire  [4:0]  fifoCnt = wrPtr_q - rdPtr_q;
   wire         push    = evtOk && !evt.setup && !evtCtl[ueps_pkg::CT_INHIBIT] && fifoCnt != 5'h10;
   wire         pop     = rdGo && araddr[11:10] == 2'h0 && rIdx == ueps_pkg::IDX_FIFO_POP && fifoCnt != 5'h0;
   wire  [15:0] pushA   = ptr_q + {8'h00, evtIdx, 3'h0};
   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_q <= 5'h0;
         rdPtr_q <= 5'h0;
      end else begin
         if (push) wrPtr_q <= wrPtr_q + 5'h1;
         if (pop) rdPtr_q <= rdPtr_q + 5'h1;
      end
   end
   always_ff @(posedge clk) begin
      if (push) fifoMem[wrPtr_q[3:0]] <= pushA;
   end

   // ==========================================================================
   // Flags B: transaction flag is a level from the FIFO or software
   logic       trnSw_q, setup_q;
   always_ff @(posedge clk) begin
      if (rst) begin
         trnSw_q <= 1'b0;
         setup_q <= 1'b0;
      end else begin
         trnSw_q <= (trnSw_q && !clrSwB[ueps_pkg::FB_TRN]) || setSwB[ueps_pkg::FB_TRN];
         setup_q <= (setup_q && !clrSwB[ueps_pkg::FB_SETUP]) || setSwB[ueps_pkg::FB_SETUP]
                    || (evtOk && evt.setup);
      end
   end
   wire       trnFlag = trnSw_q || fifoCnt != 5'h0;
   wire [7:0] flagsB  = {6'h00, trnFlag, setup_q};

   // ==========================================================================
   // Interrupt
   wire irqSrc = (irqA_q[ueps_pkg::IA_BUSEV] && (flagsA[ueps_pkg::FA_SUSPEND] || flagsA[ueps_pkg::FA_RESUME]
                  || flagsA[ueps_pkg::FA_BUSRST]))
              || (irqA_q[ueps_pkg::IA_BUSERR] && (flagsA[ueps_pkg::FA_CRC] || flagsA[ueps_pkg::FA_UNF]
                  || flagsA[ueps_pkg::FA_OVF]))
              || (irqA_q[ueps_pkg::IA_STALL] && flagsA[ueps_pkg::FA_STALL])
              || |(irqB_q & flagsB);
   assign irq = irqSrc && irqA_q[1:0] != 2'h0;

   // ==========================================================================
   // Read data and responses
   wire [7:0]  rEp   = araddr[2] ? epCtrl[rIdx[5:1]] : epStat[rIdx[5:1]];
   wire        rMapHi = araddr[11:10] == 2'h0;
   wire        rIsEp = rMapHi && rIdx[7:6] == ueps_pkg::IDX_EP_WIN;
   wire [31:0] rWord =
      rIsEp ? {24'h0, rEp} :
      !rMapHi ? 32'h0 :
      (rIdx == ueps_pkg::IDX_FLAGS_A_SET || rIdx == ueps_pkg::IDX_FLAGS_A_CLR) ? {24'h0, flagsA} :
      (rIdx == ueps_pkg::IDX_FLAGS_B_SET || rIdx == ueps_pkg::IDX_FLAGS_B_CLR) ? {24'h0, flagsB} :
      rIdx == ueps_pkg::IDX_PTR_LO ? {24'h0, ptr_q[7:0]} :
      rIdx == ueps_pkg::IDX_PTR_HI ? {24'h0, ptr_q[15:8]} :
      rIdx == ueps_pkg::IDX_IRQ_A ? {24'h0, irqA_q} :
      rIdx == ueps_pkg::IDX_IRQ_B ? {24'h0, irqB_q} :
      rIdx == ueps_pkg::IDX_TRIM_LO ? {24'h0, trim_q[7:0]} :
      rIdx == ueps_pkg::IDX_TRIM_HI ? {24'h0, trim_q[15:8]} :
      rIdx == ueps_pkg::IDX_FIFO_POP ? {15'h0, fifoCnt != 5'h0, fifoMem[rdPtr_q[3:0]]} : 32'h0;
   wire        rMap  = rIsEp || (rMapHi && (rIdx == ueps_pkg::IDX_FLAGS_A_SET || rIdx == ueps_pkg::IDX_FLAGS_A_CLR
                       || rIdx == ueps_pkg::IDX_FLAGS_B_SET || rIdx == ueps_pkg::IDX_FLAGS_B_CLR
                       || rIdx == ueps_pkg::IDX_PTR_LO || rIdx == ueps_pkg::IDX_PTR_HI
                       || rIdx == ueps_pkg::IDX_IRQ_A || rIdx == ueps_pkg::IDX_IRQ_B
                       || rIdx == ueps_pkg::IDX_TRIM_LO || rIdx == ueps_pkg::IDX_TRIM_HI
                       || rIdx == ueps_pkg::IDX_FIFO_POP));
   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid_q <= 1'b0;
         bresp_q  <= ueps_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rresp_q  <= ueps_pkg::RESP_OKAY;
         rdata_q  <= 32'h0;
      end else begin
         if (wrGo) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wMap ? ueps_pkg::RESP_OKAY : ueps_pkg::RESP_SLVERR;
         end else if (bready) bvalid_q <= 1'b0;
         if (rdGo) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rMap ? ueps_pkg::RESP_OKAY : ueps_pkg::RESP_SLVERR;
            rdata_q  <= rWord;
         end else if (rready) rvalid_q <= 1'b0;
      end
   end

   // ==========================================================================
   // Checks
   property p_busrst;
      @(posedge clk) disable iff (rst) busReset |=> flagsA[ueps_pkg::FA_BUSRST];
   endproperty
   a_busrst: assert property (p_busrst) else $error("bus reset flag not set");
   property p_stall;
      @(posedge clk) disable iff (rst) evtEn && evt.stall |=> flagsA[ueps_pkg::FA_STALL];
   endproperty
   a_stall: assert property (p_stall) else $error("stall flag not set");
   property p_unf;
      @(posedge clk) disable iff (rst) evtEn && evt.unfOvf && evt.dirIn |=> flagsA[ueps_pkg::FA_UNF];
   endproperty
   a_unf: assert property (p_unf) else $error("underflow flag not set");
   property p_ovf;
      @(posedge clk) disable iff (rst) evtEn && evt.unfOvf && !evt.dirIn |=> flagsA[ueps_pkg::FA_OVF];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag not set");
   property p_crc;
      @(posedge clk) disable iff (rst) evtEn && evt.crcErr && evtIso |=> flagsA[ueps_pkg::FA_CRC];
   endproperty
   a_crc: assert property (p_crc) else $error("crc flag not set");
   property p_trn;
      @(posedge clk) disable iff (rst) evtOk && !evt.setup && !evtCtl[ueps_pkg::CT_INHIBIT] |=> trnFlag;
   endproperty
   a_trn: assert property (p_trn) else $error("transaction flag low with FIFO entries");
   property p_setup;
      @(posedge clk) disable iff (rst) evtOk && evt.setup |=> setup_q;
   endproperty
   a_setup: assert property (p_setup) else $error("setup flag not set");
   property p_irq;
      @(posedge clk) disable iff (rst) irq |-> irqA_q[1:0] != 2'h0
         && (|(irqB_q & flagsB) || ((|irqA_q[6:4]) && (|flagsA[6:0])));
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt without level or source");
   property p_addr;
      @(posedge clk) disable iff (rst) ##1 lkAddr == $past(ptr_q) + {8'h00, $past(lkEp), 3'h0};
   endproperty
   a_addr: assert property (p_addr) else $error("entry address wrong");
   property p_resume;
      @(posedge clk) disable iff (rst) wakeAsync |=> resume_q;
   endproperty
   a_resume: assert property (p_resume) else $error("resume flag not set");
   property p_suspend;
      @(posedge clk) disable iff (rst) idleDone && !busNonIdle && !busReset
         |=> flagsA[ueps_pkg::FA_SUSPEND] && busState_q == ueps_pkg::BUS_SUSPENDED;
   endproperty
   a_suspend: assert property (p_suspend) else $error("suspend not entered");
endmodule : ueps_status_flags
`default_nettype wire

// ### ueps_status_flags_bench.sv
// Self-checking bench for the endpoint status block
`timescale 1ns/100ps
`default_nettype none
module ueps_status_flags_bench;
   logic clk = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, go = 0;
   logic lineUp = 1, resetSig = 0, awready, wready, bvalid, arready, rvalid, lkNak, lkToggle, lkToggleCheck;
   logic lkStall, lkMulti, rxDiscard, wakeRequest, irq, busReset, busNonIdle;
   logic [11:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, rd32;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp;
   logic [4:0] lkEp = 0, e, e2;
   logic [10:0] rxByteCount = 0, lkMaxBytes;
   logic [15:0] lkAddr, padTrim, trim;
   ueps_pkg::ueps_evt_t cmd = '0, evt;
   ueps_pkg::ueps_ep_type_t lkType;
   int n_errors = 0, compares = 0, cyc = 0, st, nb;
   int fq[$];
   always #50 clk = ~clk;
   ueps_host_model host (.clk(clk), .rst(rst), .go(go), .cmd(cmd), .lineUp(lineUp), .resetSig(resetSig),
      .evt(evt), .busNonIdle(busNonIdle), .busReset(busReset));
   ueps_status_flags #(.IDLE_CYC(20)) uut (.clk(clk), .rst(rst), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .busReset(busReset), .busNonIdle(busNonIdle), .evt(evt),
      .lkEp(lkEp), .rxByteCount(rxByteCount), .lkType(lkType), .lkAddr(lkAddr), .lkNak(lkNak),
      .lkToggle(lkToggle), .lkToggleCheck(lkToggleCheck), .lkStall(lkStall), .lkMulti(lkMulti),
      .lkMaxBytes(lkMaxBytes), .rxDiscard(rxDiscard), .padTrim(padTrim), .wakeRequest(wakeRequest), .irq(irq));
   task stop_test;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_errors++;
         stop_test;
      end
   end
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task wr(input logic [7:0] i, input logic [7:0] d);
      awaddr <= {2'b00, i, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      @(posedge clk);
      while (!awready) @(posedge clk);
      awvalid <= 0;
      wvalid <= 0;
      while (!bvalid) @(posedge clk);
   endtask : wr
   task rd(input logic [7:0] i);
      araddr <= {2'b00, i, 2'b00};
      arvalid <= 1;
      rready <= 1;
      @(posedge clk);
      while (!arready) @(posedge clk);
      arvalid <= 0;
      while (!rvalid) @(posedge clk);
      rd32 = rdata;
   endtask : rd
   task ev(input logic [4:0] n, input logic [4:0] f);
      cmd <= '{valid: 1'b1, epNum: n[4:1], dirIn: n[0], setup: f[4], success: f[3], stall: f[2],
               unfOvf: f[1], crcErr: f[0]};
      go <= 1;
      @(posedge clk);
      go <= 0;
      repeat (2) @(posedge clk);
   endtask : ev
   initial begin
      void'($urandom(32'hff8e));
      trim = $urandom;
      e = {4'($urandom % 16), 1'b1};
      e2 = e ^ 5'h02;
      repeat (8) @(posedge clk);
      rst <= 0;
      rd(ueps_pkg::IDX_TRIM_HI);
      chk("trim reset", 0, rd32);
      wr(ueps_pkg::IDX_TRIM_LO, trim[7:0]);
      wr(ueps_pkg::IDX_TRIM_HI, trim[15:8]);
      rd(ueps_pkg::IDX_TRIM_LO);
      chk("trim low", {24'h0, trim[7:0]}, rd32);
      chk("padTrim", {16'h0, trim}, {16'h0, padTrim});
      wr(ueps_pkg::IDX_FLAGS_B_SET, 8'h03);
      rd(ueps_pkg::IDX_FLAGS_B_CLR);
      chk("flags b set", 3, rd32);
      wr(ueps_pkg::IDX_FLAGS_B_CLR, 8'h01);
      rd(ueps_pkg::IDX_FLAGS_B_SET);
      chk("flags b clr", 2, rd32);
      wr(ueps_pkg::IDX_FLAGS_B_CLR, 8'h02);
      $display("test registers done");
      wr(ueps_pkg::IDX_PTR_LO, 8'h40);
      wr(ueps_pkg::IDX_PTR_HI, 8'h12);
      wr(8'h41 + 2 * e, 8'ha4);
      nb = $urandom % 16;
      lkEp <= e;
      rxByteCount <= 11'(nb);
      repeat (2) @(posedge clk);
      chk("lkType", ueps_pkg::EP_BULK, lkType);
      chk("lkAddr", 16'h1240 + 8 * e, lkAddr);
      chk("rxDiscard", nb >= 8, rxDiscard);
      chk("lookup", {2'b11, 11'd8}, {lkStall, lkMulti, lkMaxBytes});
      ev(e2, 5'b00100);
      ev(e, 5'b00100);
      resetSig <= 1;
      @(posedge clk);
      resetSig <= 0;
      repeat (3) @(posedge clk);
      rd(ueps_pkg::IDX_FLAGS_A_SET);
      chk("flags a", 8'h11, rd32);
      chk("irq off", 0, irq);
      wr(ueps_pkg::IDX_IRQ_A, 8'h10);
      chk("irq no level", 0, irq);
      wr(ueps_pkg::IDX_IRQ_A, 8'h11);
      chk("irq on", 1, irq);
      rd(8'h40 + 2 * e2);
      chk("disabled status", 0, rd32);
      st = 8'h80;
      ev(e, 5'b01000);
      st = (st | 8'h32) ^ 1;
      fq.push_back(32'h11240 + 8 * e);
      rd(8'h40 + 2 * e);
      chk("status done", st, rd32);
      chk("lk nak toggle", 3'b111, {lkNak, lkToggle, lkToggleCheck});
      rd(ueps_pkg::IDX_FLAGS_B_CLR);
      chk("trn flag", 2, rd32);
      rd(ueps_pkg::IDX_FIFO_POP);
      chk("fifo entry", fq.pop_front(), rd32);
      wr(8'h40 + 2 * e, 8'h81);
      rd(8'h40 + 2 * e);
      chk("status clr", st & 8'h7f, rd32);
      wr(8'h41 + 2 * (e ^ 1), 8'hc0);
      ev(e ^ 1, 5'b00011);
      ev(e, 5'b11010);
      st = ((st & 8'h7f) | 8'h52) ^ 1;
      rd(ueps_pkg::IDX_FLAGS_A_SET);
      chk("flags a err", 8'h1f, rd32);
      rd(8'h40 + 2 * (e ^ 1));
      chk("iso status", 8'hc0, rd32);
      rd(8'h40 + 2 * e);
      chk("status setup", st, rd32);
      rd(ueps_pkg::IDX_FLAGS_B_SET);
      chk("setup flag", 1, rd32);
      rd(8'h20);
      chk("unmapped", ueps_pkg::RESP_SLVERR, rresp);
      $display("test endpoint done");
      lineUp <= 0;
      repeat (30) @(posedge clk);
      rd(ueps_pkg::IDX_FLAGS_A_CLR);
      chk("suspend", 8'h40, rd32 & 8'h40);
      lineUp <= 1;
      repeat (3) @(posedge clk);
      chk("wake", 1, wakeRequest);
      rd(ueps_pkg::IDX_FLAGS_A_CLR);
      chk("resume flag", 8'h20, rd32 & 8'h20);
      $display("test idle done");
      stop_test;
   end
endmodule : ueps_status_flags_bench
`default_nettype wire
